//--- src/psda_cfg.svh
`ifndef PSDA_CFG_SVH
`define PSDA_CFG_SVH

// register byte offsets
`define PSDA_OFF_TABLE_PAGE 12'h000
`define PSDA_OFF_VIS_PAGE 12'h004
`define PSDA_OFF_CORE_CTRL 12'h008
`define PSDA_OFF_STATUS 12'h00c

// field positions
`define PSDA_CTRL_WIN_EN_BIT 2
`define PSDA_TPAGE_CFG_BIT 7
`define PSDA_EA_WIN_BIT 15

// reset values
`define PSDA_TPAGE_RST 8'h00
`define PSDA_VPAGE_RST 8'h00
`define PSDA_CTRL_RST 16'h0000

// extra stall cycles
`define PSDA_XTRA_XFER 2'h1
`define PSDA_XTRA_OTHER 2'h2
`define PSDA_XTRA_LOOP_EDGE 2'h2
`define PSDA_XTRA_NONE 2'h0

`endif

//--- src/psda_pkg.sv
package psda_pkg;

	typedef enum logic [2:0]
	{
		OP_DATA_RD = 3'h0,
		OP_DATA_WR = 3'h1,
		OP_TRD_LOW = 3'h2,
		OP_TRD_HIGH = 3'h3,
		OP_TWT_LOW = 3'h4,
		OP_TWT_HIGH = 3'h5
	} psda_op_e;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'b0001,
		ST_ACC = 4'b0010,
		ST_CAP = 4'b0100,
		ST_XTRA = 4'b1000
	} psda_state_e;

endpackage : psda_pkg

//--- src/psda_bridge.sv
// Functional notes
// - table_read_low_op in word mode returns program bits 15..0 as the result.
// - table_read_low_op byte mode: byte select 1 picks upper byte, 0 picks lower.
// - table_read_high_op word mode returns bits 23..16 low, upper byte zero.
// - table_read_high_op byte mode: select 0 gives bits 23..16, select 1 gives zero.
// - only high table ops reach program bits 23..16.
// - program address steps by two per word; low and high spaces share addresses.
// - table_page_reg selects region; its bit 7 chooses configuration memory.
// - remap only when address bit 15 set and const_window_enable is set.
// - window covers 8000h upward, mapped onto one 16K-word program page.
// - remapped address is visibility_page_reg above address bits 14..0.
// - window read returns only the low 16 bits of the program word.
// - window data read can stretch the instruction by up to two extra cycles.
// - window is suspended while a table read or write is in progress.
// - outside loops: transfer ops one extra cycle, others two.
// - in loops: two extra on edge iterations, none otherwise.
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "psda_cfg.svh"
module psda_bridge
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// core load/store request
	input wire logic core_req,
	input wire logic [2:0] core_op,
	input wire logic [15:0] core_ea,
	input wire logic core_byte,
	input wire logic [15:0] core_wdata,
	input wire logic core_xfer_op,
	input wire logic core_in_loop,
	input wire logic core_loop_edge,
	output logic core_busy,
	output logic core_ack,
	output logic [15:0] core_rdata,
	// program memory
	output logic pmem_rd,
	output logic pmem_wr_low,
	output logic pmem_wr_high,
	output logic [23:0] pmem_addr,
	output logic pmem_cfg,
	output logic pmem_byte,
	output logic [15:0] pmem_wdata,
	input wire logic [23:0] pmem_rdata,
	// data memory
	output logic dmem_req,
	output logic dmem_we,
	output logic dmem_byte,
	output logic [15:0] dmem_addr,
	output logic [15:0] dmem_wdata,
	input wire logic [15:0] dmem_rdata
);

	function automatic logic [15:0] pick_byte(input logic [15:0] w, input logic bsel);
		pick_byte = bsel ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
	endfunction : pick_byte

	function automatic logic [1:0] extra_cycles(input logic xfer, input logic in_loop,
		input logic edge_it);
		if (in_loop)
			extra_cycles = edge_it ? `PSDA_XTRA_LOOP_EDGE : `PSDA_XTRA_NONE;
		else
			extra_cycles = xfer ? `PSDA_XTRA_XFER : `PSDA_XTRA_OTHER;
	endfunction : extra_cycles

	// registers
	logic [7:0] tpage_r;
	logic [7:0] vpage_r;
	logic [15:0] ctrl_r;
	psda_pkg::psda_state_e st_r;
	psda_pkg::psda_state_e st_nxt;
	psda_pkg::psda_op_e op_r;
	logic win_r;
	logic tbl_r;
	logic byte_r;
	logic bsel_r;
	logic [1:0] cnt_r;

	// bus decode
	logic bus_take;
	logic wr_pend_r;
	logic [11:0] wr_addr_r;
	wire logic [11:0] bus_off = haddr[11:0];
	wire logic [31:0] rd_val =
		(bus_off == `PSDA_OFF_TABLE_PAGE) ? {24'h000000, tpage_r} :
		(bus_off == `PSDA_OFF_VIS_PAGE) ? {24'h000000, vpage_r} :
		(bus_off == `PSDA_OFF_CORE_CTRL) ? {16'h0000, ctrl_r} :
		(bus_off == `PSDA_OFF_STATUS) ? {28'h0000000, st_r} : 32'h00000000;
	assign bus_take = hsel && hready && htrans[1];

	// request decode
	wire logic idle = (st_r == psda_pkg::ST_IDLE);
	wire logic take = core_req && idle;
	wire psda_pkg::psda_op_e op_in = psda_pkg::psda_op_e'(core_op);
	wire logic is_tbl = (op_in != psda_pkg::OP_DATA_RD) && (op_in != psda_pkg::OP_DATA_WR);
	wire logic win_en = ctrl_r[`PSDA_CTRL_WIN_EN_BIT];
	wire logic is_win = !is_tbl && core_ea[`PSDA_EA_WIN_BIT] && win_en;
	wire logic is_win_rd = is_win && (op_in == psda_pkg::OP_DATA_RD);
	wire logic [23:0] tbl_addr = {tpage_r, core_ea[15:1], 1'b0};
	wire logic [23:0] win_addr = {1'b0, vpage_r, core_ea[14:1], 1'b0};
	wire logic [1:0] xtra = is_win_rd ?
		extra_cycles(core_xfer_op, core_in_loop, core_loop_edge) : `PSDA_XTRA_NONE;

	// result select
	wire logic [15:0] res_low = byte_r ? pick_byte(pmem_rdata[15:0], bsel_r)
		: pmem_rdata[15:0];
	wire logic [15:0] res_high = (byte_r && bsel_r) ? 16'h0000
		: {8'h00, pmem_rdata[23:16]};
	wire logic [15:0] res_data = byte_r ? pick_byte(dmem_rdata, bsel_r) : dmem_rdata;
	wire logic [15:0] res_nxt =
		(op_r == psda_pkg::OP_TRD_HIGH) ? res_high :
		(op_r == psda_pkg::OP_TRD_LOW) ? res_low :
		(op_r == psda_pkg::OP_DATA_RD) ? (win_r ? res_low : res_data) : 16'h0000;
	wire logic fin_cap = (st_r == psda_pkg::ST_CAP) && (cnt_r == 2'h0);
	wire logic fin_xtra = (st_r == psda_pkg::ST_XTRA) && (cnt_r == 2'h1);

	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			psda_pkg::ST_IDLE: if (core_req) st_nxt = psda_pkg::ST_ACC;
			psda_pkg::ST_ACC: st_nxt = psda_pkg::ST_CAP;
			psda_pkg::ST_CAP: st_nxt = fin_cap ? psda_pkg::ST_IDLE : psda_pkg::ST_XTRA;
			psda_pkg::ST_XTRA: if (fin_xtra) st_nxt = psda_pkg::ST_IDLE;
			default: st_nxt = psda_pkg::ST_IDLE;
		endcase
	end

	// register bus slave
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 12'h000;
			hrdata <= 32'h00000000;
		end
		else
		begin
			wr_pend_r <= bus_take && hwrite;
			wr_addr_r <= bus_off;
			if (bus_take && !hwrite)
				hrdata <= rd_val;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tpage_r <= `PSDA_TPAGE_RST;
			vpage_r <= `PSDA_VPAGE_RST;
			ctrl_r <= `PSDA_CTRL_RST;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else if (wr_pend_r)
		begin
			if (wr_addr_r == `PSDA_OFF_TABLE_PAGE)
				tpage_r <= hwdata[7:0];
			if (wr_addr_r == `PSDA_OFF_VIS_PAGE)
				vpage_r <= hwdata[7:0];
			if (wr_addr_r == `PSDA_OFF_CORE_CTRL)
				ctrl_r <= hwdata[15:0];
		end
	end

	// access sequencer; requests wait while busy, so a table op keeps the window shut
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r <= psda_pkg::ST_IDLE;
			op_r <= psda_pkg::OP_DATA_RD;
			win_r <= 1'b0;
			tbl_r <= 1'b0;
			byte_r <= 1'b0;
			bsel_r <= 1'b0;
			cnt_r <= 2'h0;
		end
		else
		begin
			st_r <= st_nxt;
			if (take)
			begin
				op_r <= op_in;
				win_r <= is_win;
				tbl_r <= is_tbl;
				byte_r <= core_byte;
				bsel_r <= core_ea[0];
				cnt_r <= xtra;
			end
			else if (st_r == psda_pkg::ST_XTRA)
				cnt_r <= cnt_r - 2'h1;
		end
	end

	// core and memory strobes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			core_busy <= 1'b0;
			core_ack <= 1'b0;
			core_rdata <= 16'h0000;
			pmem_rd <= 1'b0;
			pmem_wr_low <= 1'b0;
			pmem_wr_high <= 1'b0;
			pmem_addr <= 24'h000000;
			pmem_cfg <= 1'b0;
			pmem_byte <= 1'b0;
			pmem_wdata <= 16'h0000;
			dmem_req <= 1'b0;
			dmem_we <= 1'b0;
			dmem_byte <= 1'b0;
			dmem_addr <= 16'h0000;
			dmem_wdata <= 16'h0000;
		end
		else
		begin
			core_busy <= (st_nxt != psda_pkg::ST_IDLE);
			core_ack <= fin_cap || fin_xtra;
			if (st_r == psda_pkg::ST_CAP)
				core_rdata <= res_nxt;
			pmem_rd <= take && (is_win_rd || op_in == psda_pkg::OP_TRD_LOW
				|| op_in == psda_pkg::OP_TRD_HIGH);
			pmem_wr_low <= take && (op_in == psda_pkg::OP_TWT_LOW);
			pmem_wr_high <= take && (op_in == psda_pkg::OP_TWT_HIGH);
			dmem_req <= take && !is_tbl && !is_win;
			dmem_we <= take && (op_in == psda_pkg::OP_DATA_WR) && !is_win;
			if (take)
			begin
				pmem_addr <= is_tbl ? tbl_addr : win_addr;
				pmem_cfg <= is_tbl && tpage_r[`PSDA_TPAGE_CFG_BIT];
				pmem_byte <= core_byte;
				pmem_wdata <= core_wdata;
				dmem_byte <= core_byte;
				dmem_addr <= core_ea;
				dmem_wdata <= core_wdata;
			end
		end
	end

	// checks
	a_tbl_addr_form: assert property (@(posedge hclk) disable iff (!hresetn)
		take && is_tbl |=> pmem_addr == {$past(tpage_r), $past(core_ea[15:1]), 1'b0}
		&& pmem_cfg == $past(tpage_r[7]))
		else $error("table address wrong");

	a_win_addr_form: assert property (@(posedge hclk) disable iff (!hresetn)
		take && is_win_rd |=> pmem_rd && pmem_addr[22:15] == $past(vpage_r)
		&& pmem_addr[14:1] == $past(core_ea[14:1]) && !pmem_addr[23])
		else $error("window address wrong");

	a_win_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		take && op_in == psda_pkg::OP_DATA_RD && !(core_ea[15] && win_en)
		|=> dmem_req && !pmem_rd)
		else $error("window used without enable");

	a_plain_latency: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !is_win |-> ##1 !core_ack ##1 !core_ack ##1 core_ack)
		else $error("plain access latency wrong");

	a_win_other_xtra: assert property (@(posedge hclk) disable iff (!hresetn)
		take && is_win_rd && !core_in_loop && !core_xfer_op
		|-> ##1 !core_ack [*4] ##1 core_ack)
		else $error("window access not two extra");

	a_win_xfer_xtra: assert property (@(posedge hclk) disable iff (!hresetn)
		take && is_win_rd && !core_in_loop && core_xfer_op
		|-> ##1 !core_ack [*3] ##1 core_ack)
		else $error("transfer window access not one extra");

	a_loop_fast: assert property (@(posedge hclk) disable iff (!hresetn)
		take && is_win_rd && core_in_loop && !core_loop_edge |-> ##3 core_ack)
		else $error("loop window access stretched");

	a_high_phantom: assert property (@(posedge hclk) disable iff (!hresetn)
		core_ack && op_r == psda_pkg::OP_TRD_HIGH |-> core_rdata[15:8] == 8'h00)
		else $error("phantom byte not zero");

	a_low_word: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r == psda_pkg::ST_CAP && op_r == psda_pkg::OP_TRD_LOW && !byte_r
		|=> core_rdata == $past(pmem_rdata[15:0]))
		else $error("low word read wrong");

	a_busy_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
		core_busy && tbl_r |-> !take && !dmem_req)
		else $error("request taken during table op");

	a_loop_edge_xtra: assert property (@(posedge hclk) disable iff (!hresetn)
		take && is_win_rd && core_in_loop && core_loop_edge
		|-> ##1 !core_ack [*4] ##1 core_ack)
		else $error("loop edge window access not two extra");

	a_low_byte_sel: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r == psda_pkg::ST_CAP && op_r == psda_pkg::OP_TRD_LOW && byte_r
		|=> core_rdata == {8'h00, ($past(bsel_r) ? $past(pmem_rdata[15:8])
		: $past(pmem_rdata[7:0]))})
		else $error("low byte select wrong");

	a_high_word: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r == psda_pkg::ST_CAP && op_r == psda_pkg::OP_TRD_HIGH && !byte_r
		|=> core_rdata == {8'h00, $past(pmem_rdata[23:16])})
		else $error("high word read wrong");

	a_high_byte_sel: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r == psda_pkg::ST_CAP && op_r == psda_pkg::OP_TRD_HIGH && byte_r
		|=> core_rdata == ($past(bsel_r) ? 16'h0000 : {8'h00, $past(pmem_rdata[23:16])}))
		else $error("high byte select wrong");

	a_win_low_data: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r == psda_pkg::ST_CAP && op_r == psda_pkg::OP_DATA_RD && win_r && !byte_r
		|=> core_rdata == $past(pmem_rdata[15:0]))
		else $error("window read data wrong");

	a_high_wr_only: assert property (@(posedge hclk) disable iff (!hresetn)
		pmem_wr_high |-> $past(take) && $past(op_in) == psda_pkg::OP_TWT_HIGH)
		else $error("upper byte written by wrong op");

	a_win_no_data: assert property (@(posedge hclk) disable iff (!hresetn)
		take && is_win |=> !dmem_req && !dmem_we)
		else $error("window access reached data memory");

	a_data_route: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !is_tbl && !is_win
		|=> dmem_req && !pmem_rd && !pmem_wr_low && !pmem_wr_high)
		else $error("plain access left data memory");

	a_tbl_no_remap: assert property (@(posedge hclk) disable iff (!hresetn)
		take && is_tbl && core_ea[15] && win_en
		|=> pmem_addr[23:16] == $past(tpage_r) && !dmem_req)
		else $error("table op remapped by window");

endmodule : psda_bridge

//--- testbench/psda_mem_model.sv
`timescale 1ns/1ps
// program and data memory behind the bridge
module psda_mem_model
(
	// clock
	input wire logic hclk,
	// program memory
	input wire logic pmem_rd,
	input wire logic [23:0] pmem_addr,
	output logic [23:0] pmem_rdata,
	// data memory
	input wire logic dmem_req,
	input wire logic [15:0] dmem_addr,
	output logic [15:0] dmem_rdata
);
	initial
	begin
		pmem_rdata = 24'h0;
		dmem_rdata = 16'h0;
	end
	// answer one cycle after the strobe, otherwise the lines keep toggling
	always @(posedge hclk)
	begin
		pmem_rdata <= pmem_rd ? {pmem_addr[7:0] ^ 8'h5a, ~pmem_addr[15:0]} : ~pmem_rdata;
		dmem_rdata <= dmem_req ? ~dmem_addr : ~dmem_rdata;
	end
endmodule : psda_mem_model

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
	logic hclk, hresetn, hwrite, hreadyout, core_req, core_ack, pmem_rd, pmem_cfg, dmem_req;
	logic pwl, pwh;
	logic core_busy, dmem_we, pmem_byte, dmem_byte, hresp;
	logic [15:0] pmem_wdata, dmem_wdata;
	logic [1:0] htrans;
	logic [2:0] core_op;
	logic [3:0] fl;
	logic [15:0] core_ea, core_rdata, dmem_addr, dmem_rdata;
	logic [23:0] pmem_addr, pmem_rdata, p;
	logic [31:0] haddr, hwdata, hrdata, q;
	int bad_count = 0;
	int cmp_count = 0;
	psda_bridge psda_bridge_inst
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .core_req(core_req), .core_op(core_op),
		.core_ea(core_ea), .core_byte(fl[3]), .core_wdata(16'h5a5a), .core_xfer_op(fl[2]),
		.core_in_loop(fl[1]), .core_loop_edge(fl[0]), .core_busy(core_busy),
		.core_ack(core_ack),
		.core_rdata(core_rdata), .pmem_rd(pmem_rd), .pmem_wr_low(pwl), .pmem_wr_high(pwh),
		.pmem_addr(pmem_addr), .pmem_cfg(pmem_cfg), .pmem_byte(pmem_byte),
		.pmem_wdata(pmem_wdata),
		.pmem_rdata(pmem_rdata), .dmem_req(dmem_req), .dmem_we(dmem_we),
		.dmem_byte(dmem_byte),
		.dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata)
	);
	psda_mem_model psda_mem_model_inst
	(
		.hclk(hclk), .pmem_rd(pmem_rd), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
		.dmem_req(dmem_req), .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata)
	);
	function automatic logic [23:0] pw(input logic [23:0] a);
		return {a[7:0] ^ 8'h5a, ~a[15:0]};
	endfunction : pw
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// bounded wait for hready at a rising edge
	task automatic hw();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
		begin
			n++;
			if (n > 50)
			begin
				bad_count++;
				close_out();
			end
			@(posedge hclk);
		end
	endtask : hw
	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		hw();
		htrans <= 2'h0;
		hwdata <= d;
		hw();
		q = hrdata;
		chk("response", hresp, 1'b0);
	endtask : ahb
	task automatic rr(input logic [11:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk("register", q, e);
	endtask : rr
	// f: byte, transfer op, in loop, loop edge; r: program route, data route
	task automatic cop(input logic [2:0] op, input logic [15:0] ea, input logic [3:0] f,
		input logic [15:0] er, input int lat, input logic [1:0] r, input logic [24:0] pa);
		int n;
		logic [1:0] rs;
		logic [24:0] ps;
		logic [15:0] ds;
		rs = 2'h0;
		n = 0;
		core_req <= 1'b1;
		core_op <= op;
		core_ea <= ea;
		fl <= f;
		@(posedge hclk);
		core_req <= 1'b0;
		do
		begin
			#1;
			n++;
			if (n == 1)
			begin
				chk("busy", core_busy, 1'b1);
				chk("strobes", {pmem_rd, pwl, pwh, dmem_req, dmem_we},
					{r[1] && op inside {3'h0, 3'h2, 3'h3}, op == 3'h4, op == 3'h5, r[0],
					r[0] && op == 3'h1});
				chk("byte mode", {pmem_byte, dmem_byte}, {2{f[3]}});
				chk("write data", {pmem_wdata, dmem_wdata}, 32'h5a5a5a5a);
			end
			if (n == 2)
				chk("strobe width", {pmem_rd, pwl, pwh, dmem_req, dmem_we}, 5'h00);
			if ((pmem_rd | pwl | pwh) === 1'b1)
			begin
				rs[1] = 1'b1;
				ps = {pmem_cfg, pmem_addr};
			end
			if (dmem_req === 1'b1)
			begin
				rs[0] = 1'b1;
				ds = dmem_addr;
			end
			if (core_ack !== 1'b1)
				@(posedge hclk);
		end
		while (core_ack !== 1'b1 && n < 12);
		if (core_ack !== 1'b1)
		begin
			bad_count++;
			close_out();
		end
		chk("latency", n, lat);
		chk("route", rs, r);
		if (r[1])
			chk("program address", ps, pa);
		if (r[0])
			chk("data address", ds, ea);
		if (op inside {3'h0, 3'h2, 3'h3})
			chk("read data", core_rdata, er);
		chk("busy at ack", core_busy, 1'b0);
		@(posedge hclk);
	endtask : cop
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	initial
	begin
		hresetn = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		core_req = 1'b0;
		core_op = 3'h0;
		core_ea = 16'h0;
		fl = 4'h0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rr(12'h000, 32'h0);
		rr(12'h004, 32'h0);
		rr(12'h008, 32'h0);
		rr(12'h00c, 32'h1);
		ahb(1'b1, 12'h000, 32'hffff_ff12);
		ahb(1'b1, 12'h004, 32'h0000_009a);
		ahb(1'b1, 12'h008, 32'hffff_a5a4);
		ahb(1'b1, 12'h010, 32'h1234_5678);
		rr(12'h000, 32'h12);
		rr(12'h004, 32'h9a);
		rr(12'h008, 32'ha5a4);
		rr(12'h010, 32'h0);
		$display("test done: registers");
		p = pw(24'h121234);
		cop(3'h2, 16'h1234, 4'h0, p[15:0], 3, 2'h2, 25'h0121234);
		cop(3'h2, 16'h1235, 4'h8, {8'h0, p[15:8]}, 3, 2'h2, 25'h0121234);
		cop(3'h2, 16'h1234, 4'h8, {8'h0, p[7:0]}, 3, 2'h2, 25'h0121234);
		cop(3'h3, 16'h1234, 4'h0, {8'h0, p[23:16]}, 3, 2'h2, 25'h0121234);
		cop(3'h3, 16'h1234, 4'h8, {8'h0, p[23:16]}, 3, 2'h2, 25'h0121234);
		cop(3'h3, 16'h1235, 4'h8, 16'h0, 3, 2'h2, 25'h0121234);
		p = pw(24'h12c246);
		cop(3'h2, 16'hc246, 4'h0, p[15:0], 3, 2'h2, 25'h012c246);
		ahb(1'b1, 12'h000, 32'h0000_0092);
		p = pw(24'h921234);
		cop(3'h3, 16'h1234, 4'h0, {8'h0, p[23:16]}, 3, 2'h2, 25'h1921234);
		cop(3'h4, 16'h0010, 4'h0, 16'h0, 3, 2'h2, 25'h1920010);
		cop(3'h5, 16'h0010, 4'h0, 16'h0, 3, 2'h2, 25'h1920010);
		$display("test done: table");
		p = pw(24'h4d4246);
		cop(3'h0, 16'hc246, 4'h0, p[15:0], 5, 2'h2, 25'h04d4246);
		cop(3'h0, 16'hc246, 4'h4, p[15:0], 4, 2'h2, 25'h04d4246);
		cop(3'h0, 16'hc246, 4'h2, p[15:0], 3, 2'h2, 25'h04d4246);
		cop(3'h0, 16'hc246, 4'h3, p[15:0], 5, 2'h2, 25'h04d4246);
		cop(3'h0, 16'hc247, 4'h8, {8'h0, p[15:8]}, 5, 2'h2, 25'h04d4246);
		cop(3'h0, 16'h8000, 4'h0, 16'hffff, 5, 2'h2, 25'h04d0000);
		cop(3'h0, 16'h7ffe, 4'h0, 16'h8001, 3, 2'h1, 25'h0);
		cop(3'h1, 16'hc246, 4'h0, 16'h0, 3, 2'h0, 25'h0);
		$display("test done: window");
		ahb(1'b1, 12'h008, 32'h0000_a5a0);
		cop(3'h0, 16'hc246, 4'h0, 16'h3db9, 3, 2'h1, 25'h0);
		cop(3'h1, 16'h0020, 4'h0, 16'h0, 3, 2'h1, 25'h0);
		cop(3'h0, 16'h0021, 4'h8, 16'h00ff, 3, 2'h1, 25'h0);
		$display("test done: data");
		close_out();
	end
endmodule : tb
